// ==== bench/core_model.sv ====
`timescale 1ns/1ps
module core_model (
	input  wire logic        clk,
	input  wire logic        grant,
	input  wire logic        fault,
	output rpu_pkg::access_s acc
);
	initial acc = '0;
	// one access held over the taking edge; the answer stands in the following cycle
	task automatic issue(input logic [31:0] a, input rpu_pkg::op_e o, input logic p, output logic g, output logic f);
		@(posedge clk);
		acc <= '{valid: 1'b1, addr: a, op: o, priv: p};
		@(posedge clk);
		acc <= '{valid: 1'b0, addr: ~a, op: rpu_pkg::OP_EXEC, priv: ~p};
		#1;
		g = grant;
		f = fault;
	endtask
endmodule

// ==== bench/region_protection_unit_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module region_protection_unit_tb_top;
	logic                     clk = 1'b0;
	logic                     reset = 1'b1;
	rpu_pkg::access_s         acc;
	logic                     grant;
	logic                     fault;
	logic [3:0]               fault_prio;
	logic                     irq;
	logic [7:0]               reg_addr = 8'h00;
	logic [31:0]              reg_wdata = 32'h0;
	logic                     reg_wr = 1'b0;
	logic                     reg_rd = 1'b0;
	logic                     reg_priv = 1'b0;
	logic [31:0]              reg_rdata;
	int                       error_cnt = 0;
	int                       checked = 0;
	logic [31:0]              d;
	always #50 clk = ~clk;
	region_protection_unit u_region_protection_unit (.clk(clk), .reset(reset), .acc(acc), .grant(grant),
		.fault(fault), .fault_prio(fault_prio), .irq(irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_priv(reg_priv), .reg_rdata(reg_rdata));
	core_model u_core_model (.clk(clk), .grant(grant), .fault(fault), .acc(acc));
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic p);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_priv <= p;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic p);
		@(posedge clk);
		reg_addr <= a;
		reg_priv <= p;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic acc_chk(input logic [31:0] a, input rpu_pkg::op_e o, input logic p, input logic eg);
		logic g;
		logic f;
		u_core_model.issue(a, o, p, g, f);
		`CHK("grant", eg, g)
		`CHK("fault", ~eg, f)
	endtask
	function automatic logic [31:0] attr(input logic [4:0] s, input logic [5:0] pm);
		return {18'h0, pm, 2'h0, s, 1'b1};
	endfunction
	task automatic t_reset();
		rd(rpu_pkg::OFS_CTRL, 1'b1);
		`CHK("ctrl", 32'h1, d)
		acc_chk(32'h0000_2000, rpu_pkg::OP_READ, 1'b1, 1'b0);
		rd(rpu_pkg::OFS_STATUS, 1'b1);
		`CHK("status", 32'h1, d)
		wr(rpu_pkg::OFS_MASK, 32'h1, 1'b1);
		@(posedge clk);
		#1 `CHK("irq", 1'b1, irq)
		wr(rpu_pkg::OFS_STATUS, 32'h1, 1'b1);
		@(posedge clk);
		#1 `CHK("irq", 1'b0, irq)
		$display("test reset done");
	endtask
	task automatic t_unpriv();
		wr(rpu_pkg::OFS_CTRL, 32'h3, 1'b0);
		wr(rpu_pkg::OFS_RATTR0, attr(5'h1F, 6'h3F), 1'b0);
		rd(rpu_pkg::OFS_CTRL, 1'b0);
		`CHK("unpriv read", 32'h0, d)
		rd(rpu_pkg::OFS_CTRL, 1'b1);
		`CHK("ctrl", 32'h1, d)
		rd(rpu_pkg::OFS_RATTR0, 1'b1);
		`CHK("attr0", 32'h0, d)
		rd(rpu_pkg::OFS_STATUS, 1'b1);
		`CHK("status", 32'h4, d)
		wr(rpu_pkg::OFS_STATUS, 32'h7, 1'b1);
		$display("test unpriv done");
	endtask
	task automatic t_default();
		wr(rpu_pkg::OFS_CTRL, 32'h0000_0A03, 1'b1);
		#1 `CHK("fault_prio", 4'hA, fault_prio)
		for (int p = 0; p < 2; p++) begin
			for (int o = 0; o < 3; o++) begin
				acc_chk(32'h8000_0000, rpu_pkg::op_e'(o), p[0], p[0]);
			end
		end
		wr(rpu_pkg::OFS_CTRL, 32'h1, 1'b1);
		wr(rpu_pkg::OFS_STATUS, 32'h7, 1'b1);
		$display("test default done");
	endtask
	task automatic t_matrix();
		wr(rpu_pkg::OFS_RBASE0, 32'h0000_1000, 1'b1);
		rd(rpu_pkg::OFS_RBASE0, 1'b1);
		`CHK("base0", 32'h0000_1000, d)
		for (int b = 0; b < 6; b++) begin
			wr(rpu_pkg::OFS_RATTR0, attr(5'h0B, 6'(1 << b)), 1'b1);
			for (int p = 0; p < 2; p++) begin
				for (int o = 0; o < 3; o++) begin
					acc_chk(32'h0000_1800, rpu_pkg::op_e'(o), p[0], (p * 3 + o) == b);
				end
			end
		end
		rd(rpu_pkg::OFS_STATUS, 1'b1);
		`CHK("status", 32'h2, d)
		acc_chk(32'h0000_0FFF, rpu_pkg::OP_READ, 1'b0, 1'b0);
		acc_chk(32'h0000_2000, rpu_pkg::OP_READ, 1'b0, 1'b0);
		rd(rpu_pkg::OFS_STATUS, 1'b1);
		`CHK("status", 32'h3, d)
		rd(rpu_pkg::OFS_FADDR, 1'b1);
		`CHK("faddr", 32'h0000_2000, d)
		rd(rpu_pkg::OFS_FINFO, 1'b1);
		`CHK("finfo", 32'h0000_0001, d)
		$display("test matrix done");
	endtask
	task automatic t_overlap();
		wr(rpu_pkg::OFS_RATTR0, attr(5'h0B, 6'h01), 1'b1);
		wr(rpu_pkg::OFS_RBASE0 + 8'h38, 32'h0000_1000, 1'b1);
		wr(rpu_pkg::OFS_RATTR0 + 8'h38, attr(5'h07, 6'h38), 1'b1);
		acc_chk(32'h0000_1080, rpu_pkg::OP_READ, 1'b0, 1'b0);
		acc_chk(32'h0000_1080, rpu_pkg::OP_EXEC, 1'b1, 1'b1);
		acc_chk(32'h0000_1100, rpu_pkg::OP_READ, 1'b0, 1'b1);
		wr(rpu_pkg::OFS_RATTR0 + 8'h38, 32'h0000_3870, 1'b1);
		acc_chk(32'h0000_1080, rpu_pkg::OP_READ, 1'b0, 1'b1);
		wr(rpu_pkg::OFS_CTRL, 32'h0, 1'b1);
		acc_chk(32'h0000_1080, rpu_pkg::OP_WRITE, 1'b0, 1'b1);
		$display("test overlap done");
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_unpriv();
		t_default();
		t_matrix();
		t_overlap();
		stop_test();
	end
endmodule

// ==== hw/region_protection_unit.sv ====
// Contract
// [R1] regions overlap, higher index wins
// [R2] global enable, eight regions, own enables
// [R3] each region has start and size
// [R4] per-region matrix: privilege by read/write/execute
// [R5] access classed by privilege and operation
// [R6] highest enabled matching region decides
// [R7] no matching region uses default region
// [R8] default region: privileged allowed or all denied
// [R9] denied access raises access violation
// [R10] mismatch and violation raise programmable-priority fault
// [R11] checked per access; denied access suppressed
// [R12] every privilege, address, operation checked
// [R13] reset values are restrictive
// [R14] unprivileged configuration writes have no effect
// [R15] privileged software reads and writes configuration
// [R16] global enable clear: no checks, no faults
`timescale 1ns/1ps
module region_protection_unit (
	input  wire logic                       clk,
	input  wire logic                       reset,
	input  wire rpu_pkg::access_s           acc,
	output logic                            grant,
	output logic                            fault,
	output logic [rpu_pkg::PRIO_W-1:0]      fault_prio,
	output logic                            irq,
	input  wire logic [7:0]                 reg_addr,
	input  wire logic [rpu_pkg::DW-1:0]     reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	input  wire logic                       reg_priv,
	output logic [rpu_pkg::DW-1:0]          reg_rdata
);
	typedef struct packed {
		logic [rpu_pkg::DW-1:0]            ctrl;
		rpu_pkg::region_s [7:0]            rgn;
		logic [rpu_pkg::ST_W-1:0]          status;
		logic [rpu_pkg::ST_W-1:0]          mask;
		logic [rpu_pkg::AW-1:0]            faddr;
		logic [rpu_pkg::DW-1:0]            finfo;
		logic                              grant;
		logic                              fault;
		logic                              irq;
		logic [rpu_pkg::DW-1:0]            rdata;
	} state_s;

	state_s s_q;
	state_s s_d;

	// true when addr lies in [base, base + 2^(size+1)) with base aligned down
	function automatic logic in_region(input rpu_pkg::region_s r, input logic [rpu_pkg::AW-1:0] a);
		logic [rpu_pkg::AW-1:0] m;
		m = ~((32'h0000_0002 << r.size) - 32'h0000_0001);
		in_region = ((a & m) == (r.base & m));
	endfunction

	// matrix layout: [2:0] unpriv r/w/x, [5:3] priv r/w/x
	function automatic logic perm_ok(input logic [rpu_pkg::PERM_W-1:0] p, input rpu_pkg::access_s a);
		logic [1:0] i;
		i = a.op;
		perm_ok = a.priv ? p[3 + i] : p[i];
	endfunction

	logic [7:0] hit;
	genvar g;
	generate
		for (g = 0; g < rpu_pkg::NUM_REGIONS; g++) begin : g_hit
			assign hit[g] = s_q.rgn[g].en && in_region(s_q.rgn[g], acc.addr); // [R2] [R3] [R12]
		end
	endgenerate

	logic       any_hit;
	logic [2:0] win;
	logic       allow;
	always_comb begin
		any_hit = 1'b0;
		win     = 3'h0;
		for (int k = 0; k < rpu_pkg::NUM_REGIONS; k++) begin
			if (hit[k]) begin
				any_hit = 1'b1;
				win     = k[2:0]; // [R1] [R6]
			end
		end
		if (any_hit)
			allow = perm_ok(s_q.rgn[win].perm, acc); // [R4] [R5] [R9]
		else
			allow = s_q.ctrl[rpu_pkg::CTRL_DEFPRIV] && acc.priv; // [R7] [R8]
	end

	logic [7:0] rsel;
	logic       rgn_base;
	logic [2:0] ridx;
	always_comb begin
		rsel     = reg_addr - rpu_pkg::OFS_RBASE0;
		rgn_base = (rsel[2] == 1'b0);
		ridx     = rsel[5:3];
	end
	logic rgn_hit;
	assign rgn_hit = (reg_addr >= rpu_pkg::OFS_RBASE0) && (reg_addr[7:6] == 2'h1) && (reg_addr[1:0] == 2'h0);

	logic check_on;
	logic viol;
	assign check_on = acc.valid && s_q.ctrl[rpu_pkg::CTRL_ENABLE]; // [R16]
	assign viol     = check_on && !allow;

	// permission that region 7 alone would give, sampled by the priority check
	logic top_ok;
	assign top_ok = perm_ok(s_q.rgn[7].perm, acc);

	always_comb begin
		logic [rpu_pkg::ST_W-1:0] ev;
		logic                     cfg_wr;
		s_d    = s_q;
		ev     = '0;
		cfg_wr = reg_wr && reg_priv; // [R14]
		s_d.grant      = acc.valid && !viol; // [R11]
		s_d.fault      = viol; // [R9] [R10]
		if (viol) begin
			s_d.faddr = acc.addr;
			s_d.finfo = {27'h0, any_hit, acc.priv, acc.op, 1'b1};
			ev[any_hit ? rpu_pkg::ST_PERM : rpu_pkg::ST_REGION] = 1'b1; // [R10]
		end
		if (reg_wr && !reg_priv)
			ev[rpu_pkg::ST_CFGDENY] = 1'b1;
		if (cfg_wr) begin // [R15]
			case (reg_addr)
				rpu_pkg::OFS_CTRL:   s_d.ctrl   = reg_wdata;
				rpu_pkg::OFS_STATUS: s_d.status = s_q.status & ~reg_wdata[rpu_pkg::ST_W-1:0];
				rpu_pkg::OFS_MASK:   s_d.mask   = reg_wdata[rpu_pkg::ST_W-1:0];
				default: begin
					if (rgn_hit) begin
						if (rgn_base)
							s_d.rgn[ridx].base = reg_wdata;
						else begin
							s_d.rgn[ridx].en   = reg_wdata[rpu_pkg::ATTR_EN];
							s_d.rgn[ridx].size = reg_wdata[rpu_pkg::ATTR_SIZE_LO +: rpu_pkg::SIZE_W];
							s_d.rgn[ridx].perm = reg_wdata[rpu_pkg::ATTR_PERM_LO +: rpu_pkg::PERM_W];
						end
					end
				end
			endcase
		end
		// set wins over a write-one clear in the same cycle
		s_d.status = s_d.status | ev;
		s_d.rdata  = '0;
		if (reg_rd && reg_priv) begin // [R15]
			case (reg_addr)
				rpu_pkg::OFS_CTRL:   s_d.rdata = s_q.ctrl;
				rpu_pkg::OFS_STATUS: s_d.rdata = {29'h0, s_q.status};
				rpu_pkg::OFS_MASK:   s_d.rdata = {29'h0, s_q.mask};
				rpu_pkg::OFS_FADDR:  s_d.rdata = s_q.faddr;
				rpu_pkg::OFS_FINFO:  s_d.rdata = s_q.finfo;
				default: begin
					if (rgn_hit)
						s_d.rdata = rgn_base ? s_q.rgn[ridx].base :
							{18'h0, s_q.rgn[ridx].perm, 2'h0, s_q.rgn[ridx].size, s_q.rgn[ridx].en};
				end
			endcase
		end
		s_d.irq = |(s_d.status & s_d.mask);
	end

	always_ff @(posedge clk) begin
		if (reset) begin // [R13]
			s_q.ctrl   <= rpu_pkg::CTRL_RST;
			for (int k = 0; k < rpu_pkg::NUM_REGIONS; k++) begin
				s_q.rgn[k].base <= rpu_pkg::BASE_RST;
				s_q.rgn[k].en   <= 1'b0;
				s_q.rgn[k].size <= rpu_pkg::SIZE_RST;
				s_q.rgn[k].perm <= rpu_pkg::PERM_RST;
			end
			s_q.status <= rpu_pkg::ST_RST;
			s_q.mask   <= rpu_pkg::MASK_RST;
			s_q.faddr  <= '0;
			s_q.finfo  <= '0;
			s_q.grant  <= 1'b0;
			s_q.fault  <= 1'b0;
			s_q.irq    <= 1'b0;
			s_q.rdata  <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign grant      = s_q.grant;
	assign fault      = s_q.fault;
	assign fault_prio = s_q.ctrl[rpu_pkg::CTRL_PRIO_LO +: rpu_pkg::PRIO_W];
	assign irq        = s_q.irq;
	assign reg_rdata  = s_q.rdata;

	a_enable_off_quiet: assert property (@(posedge clk) disable iff (reset) // [R16]
		!s_q.ctrl[rpu_pkg::CTRL_ENABLE] && acc.valid |=> !fault && grant)
		else $error("fault while protection disabled");
	a_deny_no_grant: assert property (@(posedge clk) disable iff (reset) // [R11]
		!(grant && fault))
		else $error("access granted and faulted together");
	a_fault_sets_status: assert property (@(posedge clk) disable iff (reset) // [R10]
		fault |-> (s_q.status[rpu_pkg::ST_REGION] || s_q.status[rpu_pkg::ST_PERM]))
		else $error("fault left no status bit");
	a_unpriv_cfg_blocked: assert property (@(posedge clk) disable iff (reset) // [R14]
		reg_wr && !reg_priv |=> $stable(s_q.ctrl) && $stable(s_q.rgn) && $stable(s_q.mask))
		else $error("unprivileged write changed configuration");
	a_default_deny_unpriv: assert property (@(posedge clk) disable iff (reset) // [R8]
		check_on && !any_hit && !acc.priv |=> fault)
		else $error("unprivileged default-region access not denied");
	a_default_priv_ok: assert property (@(posedge clk) disable iff (reset) // [R7]
		check_on && !any_hit && acc.priv && s_q.ctrl[rpu_pkg::CTRL_DEFPRIV] |=> grant)
		else $error("privileged default-region access denied");
	a_top_region_wins: assert property (@(posedge clk) disable iff (reset) // [R6]
		check_on && hit[7] |=> fault == !$past(top_ok))
		else $error("region 7 did not decide");
	a_reset_restrictive: assert property (@(posedge clk) // [R13]
		reset |=> s_q.ctrl[rpu_pkg::CTRL_ENABLE] && !s_q.ctrl[rpu_pkg::CTRL_DEFPRIV] && s_q.rgn[0].perm == '0)
		else $error("reset values not restrictive");
	a_irq_follows: assert property (@(posedge clk) disable iff (reset)
		irq == |(s_q.status & s_q.mask))
		else $error("interrupt level wrong");
	a_priv_read: assert property (@(posedge clk) disable iff (reset) // [R15]
		reg_rd && reg_priv && reg_addr == rpu_pkg::OFS_CTRL |=> reg_rdata == $past(s_q.ctrl))
		else $error("control read back wrong");
endmodule

// ==== shared/rpu_pkg.sv ====
package rpu_pkg;
	localparam int NUM_REGIONS = 8;
	localparam int AW          = 32;
	localparam int DW          = 32;
	localparam int RAW         = 8;

	// register map, byte addresses of aligned words
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_MASK     = 8'h08;
	localparam logic [7:0] OFS_FADDR    = 8'h0C;
	localparam logic [7:0] OFS_FINFO    = 8'h10;
	localparam logic [7:0] OFS_RBASE0   = 8'h40;
	localparam logic [7:0] OFS_RATTR0   = 8'h44;
	localparam logic [7:0] RGN_STRIDE   = 8'h08;

	// ctrl fields
	localparam int CTRL_ENABLE  = 0;
	localparam int CTRL_DEFPRIV = 1;
	localparam int CTRL_PRIO_LO = 8;
	localparam int PRIO_W       = 4;

	// attr fields: [0] enable, [5:1] size exponent, [13:8] access matrix
	localparam int ATTR_EN      = 0;
	localparam int ATTR_SIZE_LO = 1;
	localparam int SIZE_W       = 5;
	localparam int ATTR_PERM_LO = 8;
	localparam int PERM_W       = 6;

	// status bits
	localparam int ST_REGION  = 0;
	localparam int ST_PERM    = 1;
	localparam int ST_CFGDENY = 2;
	localparam int ST_W       = 3;

	// restrictive reset values
	localparam logic [DW-1:0]     CTRL_RST  = 32'h0000_0001;
	localparam logic [AW-1:0]     BASE_RST  = 32'h0000_0000;
	localparam logic [SIZE_W-1:0] SIZE_RST  = 5'h00;
	localparam logic [PERM_W-1:0] PERM_RST  = 6'h00;
	localparam logic [ST_W-1:0]   ST_RST    = 3'h0;
	localparam logic [ST_W-1:0]   MASK_RST  = 3'h0;

	typedef enum logic [1:0] {
		OP_READ  = 2'h0,
		OP_WRITE = 2'h1,
		OP_EXEC  = 2'h2
	} op_e;

	typedef struct packed {
		logic [AW-1:0]     base;
		logic              en;
		logic [SIZE_W-1:0] size;
		logic [PERM_W-1:0] perm;
	} region_s;

	typedef struct packed {
		logic          valid;
		logic [AW-1:0] addr;
		op_e           op;
		logic          priv;
	} access_s;
endpackage
